// file: src/period_timer_pkg.sv
// Package: register map, field layout, reset values and carrier types of the period timers
package period_timer_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  typedef logic [ADDR_W-1:0] addr_t;

  // Byte addresses, one aligned 32-bit word per register
  localparam addr_t TMR_BASE = 8'h00;
  localparam addr_t TMR_STRIDE = 8'h10;
  localparam addr_t OFF_CONTROL = 8'h00;
  localparam addr_t OFF_PERIOD = 8'h04;
  localparam addr_t OFF_COUNT = 8'h08;
  localparam addr_t ADDR_TIME_BASE_SEL = 8'h30;
  localparam addr_t CAP_BASE = 8'h34;
  localparam addr_t CAP_STRIDE = 8'h08;
  localparam addr_t OFF_CAP_MODE = 8'h00;
  localparam addr_t OFF_CAP_VALUE = 8'h04;
  localparam addr_t ADDR_FLAGS = 8'h44;

  // Period timer control layout: bit 7 reads zero
  localparam int CTL_POST_LSB = 3;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_PRE_LSB = 0;
  typedef struct packed {
    logic [3:0] match_postscale_select;
    logic period_timer_run;
    logic [1:0] input_prescale_select;
  } timer_ctl_s;

  // Reset values
  localparam logic [6:0] CTL_RESET = 7'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // Input prescaler terminal counts for divide by 1, 4, 16, 64
  localparam logic [5:0] PRE_LIMIT_1 = 6'h00;
  localparam logic [5:0] PRE_LIMIT_4 = 6'h03;
  localparam logic [5:0] PRE_LIMIT_16 = 6'h0F;
  localparam logic [5:0] PRE_LIMIT_64 = 6'h3F;

  // Time base selection codes, two bits per unit
  localparam logic [1:0] PICK_RESERVED = 2'h3;

  // Capture unit mode codes
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] EDGE_LIMIT_4 = 4'h3;
  localparam logic [3:0] EDGE_LIMIT_16 = 4'hF;

  // Flag register layout
  localparam int FLAG_MATCH_LSB = 0;
  localparam int FLAG_CAP_LSB = 4;

  // Pin view of one capture unit
  typedef struct packed {
    logic pin_level;
    logic pin_direction_output;
    logic port_data;
  } cap_pin_s;

endpackage : period_timer_pkg

// file: src/period_timer_ccp_capture.sv
// Three period timers, time base selection and two capture units behind an APB slave
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Each timer's unscaled match pulse feeds the PWM time base outputs.
// - Timer a's match pulse is offered as shift clock tick to the serial port.
// - Timers do not count while the processor sleeps.
// - Count and period registers hold their values during sleep.
// - Postscale field bits 6..3 divides match events by field plus one.
// - Control bit 2 switches the timer on or off.
// - Prescale field bits 1..0 divides input by 1, 4, 16 or 64.
// - Three identical 8-bit timers; control bit 7 reads zero.
// - Every CCP and PWM unit has its own independent timer pick field.
// - PWM units pick timer at bits 7-6 and 5-4; code 11 reserved.
// - CCP units pick timer at bits 3-2 and 1-0; code 11 reserved.
// - Two identical capture units, each with control, pin and flag.
// - Capture event copies the 16-bit free-running count into the value pair.
// - Event is falling, rising, every 4th or every 16th rising edge.
// - Each capture sets the unit's capture event flag.
// - A new capture overwrites an unread captured value.
// - With the pin as output, a port data write acts as a pin edge.
// - Count equal to period gives match and reloads count to 00h.
// - Count or control write, or reset, clears pre- and postscaler.
// - Postscaler output sets the period match flag every selected match count.
module period_timer_ccp_capture
  import period_timer_pkg::*;
#(
  parameter int NUM_TIMERS = 3,
  parameter int NUM_CAPTURE = 2,
  parameter int NUM_PWM_UNITS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  input wire logic [15:0] base16_count,
  input wire cap_pin_s [NUM_CAPTURE-1:0] capture_pin,
  output logic [NUM_TIMERS-1:0] period_match,
  output logic [NUM_PWM_UNITS-1:0] pwm_time_base,
  output logic serial_shift_tick,
  output logic [NUM_TIMERS-1:0] postscaled_match,
  output logic [NUM_TIMERS-1:0] period_match_flag,
  output logic [NUM_CAPTURE-1:0] capture_event_flag,
  output logic [NUM_CAPTURE-1:0] capture_strobe
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Bus slave handshake
  // Each transfer is answered in its second access cycle.
  // The wait state keeps the read mux off the output path.
  // A write lands at the edge where pready is sampled high.
  // Unmapped addresses answer with pslverr and change nothing.

  // Answer flops and the read mux outputs behind them
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rdata_d;
  logic hit_d;

  // First access cycle waits; the second one completes
  wire access_wait = psel & penable & ~pready_q;
  wire access_done = psel & penable & pready_q;
  wire wr_en = access_done & pwrite;

  // One wait state so read data and error can come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= access_wait;
      if (access_wait) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr_q <= ~hit_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Bus answer straight from its flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Shared registers
  // Selection and flags are common to all timers and units.
  // Flags are sticky: only software clears them, by writing ones.
  // An event in the cycle of its own clear still sets the flag,
  // so software can never lose an event to a late clear.

  // Stored state and per-cycle event vectors
  logic [7:0] sel_q;
  logic [NUM_TIMERS-1:0] mflag_q;
  logic [NUM_CAPTURE-1:0] cflag_q;
  logic [NUM_TIMERS-1:0] match_d;
  logic [NUM_TIMERS-1:0] post_d;
  logic [NUM_CAPTURE-1:0] cap_d;
  logic [NUM_PWM_UNITS-1:0] base_d;


  // Decode of the two shared locations
  wire sel_wr = wr_en & (paddr == ADDR_TIME_BASE_SEL);
  wire flag_wr = wr_en & (paddr == ADDR_FLAGS);
  wire [NUM_TIMERS-1:0] mflag_clr = flag_wr ? pwdata[FLAG_MATCH_LSB +: NUM_TIMERS] : '0;
  wire [NUM_CAPTURE-1:0] cflag_clr = flag_wr ? pwdata[FLAG_CAP_LSB +: NUM_CAPTURE] : '0;

  // Flags are write-one-to-clear; a same-cycle event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= SEL_RESET;
      mflag_q <= '0;
      cflag_q <= '0;
    end else if (clk_en) begin
      if (sel_wr) sel_q <= pwdata[7:0];
      mflag_q <= (mflag_q & ~mflag_clr) | post_d;
      cflag_q <= (cflag_q & ~cflag_clr) | cap_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Period timers
  // An 8-bit up counter behind a prescaler, compared to its period.
  // The match is taken before the postscaler: it feeds the time
  // bases and the shift tick, while the postscaler paces the flag.
  // A count written above the period runs on through the wrap
  // at FFh before it can match again; software should avoid it.
  // Sleep holds the prescaler, so no partial tick is lost or
  // gained across it; a run bit change is a control write and clears it.

  // Per-timer state, indexed by timer number
  logic [7:0] count_q [NUM_TIMERS];
  logic [7:0] period_q [NUM_TIMERS];
  timer_ctl_s ctl_q [NUM_TIMERS];

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    // Timers sit one stride apart: control, period, count
    localparam addr_t BASE = addr_t'(TMR_BASE + t * TMR_STRIDE);

    // Prescaler, postscaler and terminal count of this timer
    logic [5:0] pre_q;
    logic [3:0] post_q;
    logic [5:0] pre_limit;

    // Register decode of this timer
    wire ctl_wr = wr_en & (paddr == addr_t'(BASE + OFF_CONTROL));
    wire per_wr = wr_en & (paddr == addr_t'(BASE + OFF_PERIOD));
    wire cnt_wr = wr_en & (paddr == addr_t'(BASE + OFF_COUNT));

    // Scaler clear, tick, match and postscaler terminal events
    wire scaler_clr = ctl_wr | cnt_wr;
    wire counting = ctl_q[t].period_timer_run & ~sleep;
    wire tick = counting & (pre_q == pre_limit);
    wire hit = tick & (count_q[t] == period_q[t]);
    wire post_end = hit & (post_q == ctl_q[t].match_postscale_select);

    // Input prescale terminal count
    assign pre_limit = (ctl_q[t].input_prescale_select == 2'h0) ? PRE_LIMIT_1 :
                       (ctl_q[t].input_prescale_select == 2'h1) ? PRE_LIMIT_4 :
                       (ctl_q[t].input_prescale_select == 2'h2) ? PRE_LIMIT_16 :
                       PRE_LIMIT_64;
    assign match_d[t] = hit;
    assign post_d[t] = post_end;

    // Count, period and control; sleep freezes count and period
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_q[t] <= CTL_RESET;
        period_q[t] <= PERIOD_RESET;
        count_q[t] <= COUNT_RESET;
      end else if (clk_en) begin
        if (ctl_wr) ctl_q[t] <= pwdata[6:0];
        if (per_wr) period_q[t] <= pwdata[7:0];
        if (cnt_wr) count_q[t] <= pwdata[7:0];
        else if (hit) count_q[t] <= 8'h00;
        else if (tick) count_q[t] <= count_q[t] + 8'h01;
      end
    end

    // Prescaler and postscaler counters; reset also clears them
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_q <= 6'h00;
        post_q <= 4'h0;
      end else if (clk_en) begin
        if (scaler_clr) pre_q <= 6'h00;
        else if (tick) pre_q <= 6'h00;
        else if (counting) pre_q <= pre_q + 6'h01;
        if (scaler_clr) post_q <= 4'h0;
        else if (post_end) post_q <= 4'h0;
        else if (hit) post_q <= post_q + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Time base selection, one independent two-bit pick per unit
  // Pairs from the low end: CCP a, CCP b, PWM c, PWM d.
  // The pick muxes the unregistered match; one flop follows,
  // so every consumer sees its pulse in the same cycle.

  for (genvar u = 0; u < NUM_PWM_UNITS; u++) begin : g_pick
    wire [1:0] pick = sel_q[2*u +: 2];
    // Reserved pick drives no time base rather than a guessed timer
    assign base_d[u] = (pick == PICK_RESERVED) ? 1'b0 : match_d[pick];
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Capture units
  // Each pin passes a two-flop synchroniser and a history flop.
  // Only mode codes 4 to 7 capture; any other code parks the
  // unit and clears its edge prescaler, which turns it off.
  // The free-running count is sampled at the detecting edge,
  // so the value lags the pin by the synchroniser delay.
  // Capture keeps working in sleep; only the timers stop.

  // Per-unit mode and captured value
  logic [3:0] mode_q [NUM_CAPTURE];
  logic [15:0] value_q [NUM_CAPTURE];

  for (genvar c = 0; c < NUM_CAPTURE; c++) begin : g_cap
    // Units sit one stride apart: mode, then value
    localparam addr_t BASE = addr_t'(CAP_BASE + c * CAP_STRIDE);

    // Synchroniser, history and edge prescaler of this unit
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic [3:0] edge_q;

    // Mode register decode
    wire mode_wr = wr_en & (paddr == addr_t'(BASE + OFF_CAP_MODE));
    // Output pin: the port latch is the level, so a port write makes the edge
    wire level = capture_pin[c].pin_direction_output ? capture_pin[c].port_data
                                                     : capture_pin[c].pin_level;

    // Edges of the synchronised level
    wire rise = sync2_q & ~prev_q;
    wire fall = ~sync2_q & prev_q;

    // Capture qualification by mode and edge prescaler
    wire cap_mode = (mode_q[c][3:2] == 2'b01);
    wire edge_end4 = rise & (edge_q == EDGE_LIMIT_4);
    wire edge_end16 = rise & (edge_q == EDGE_LIMIT_16);
    wire event_hit = (mode_q[c] == MODE_CAP_FALL) ? fall :
                     (mode_q[c] == MODE_CAP_RISE) ? rise :
                     (mode_q[c] == MODE_CAP_RISE4) ? edge_end4 :
                     (mode_q[c] == MODE_CAP_RISE16) ? edge_end16 : 1'b0;
    assign cap_d[c] = event_hit;

    // Two-stage synchroniser, then a third flop for the edge history
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        prev_q <= 1'b0;
      end else if (clk_en) begin
        sync1_q <= level;
        sync2_q <= sync1_q;
        prev_q <= sync2_q;
      end
    end

    // Mode, edge prescaler and captured value
    // Changing prescale mode does not clear the edge count; software turns off first
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_q[c] <= MODE_RESET;
        edge_q <= 4'h0;
        value_q[c] <= 16'h0000;
      end else if (clk_en) begin
        if (mode_wr) mode_q[c] <= pwdata[3:0];
        if (!cap_mode) edge_q <= 4'h0;
        else if (edge_end4 && mode_q[c] == MODE_CAP_RISE4) edge_q <= 4'h0;
        else if (rise) edge_q <= edge_q + 4'h1;
        if (event_hit) value_q[c] <= base16_count;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Upper bits read zero; control bit 7 reads zero because only
  // seven control bits are stored.
  // A location that matches nothing flags an error and reads 0.

  // Word for the addressed register
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    unique case (paddr)
      8'h00: rdata_d[6:0] = ctl_q[0];
      8'h04: rdata_d[7:0] = period_q[0];
      8'h08: rdata_d[7:0] = count_q[0];
      8'h10: rdata_d[6:0] = ctl_q[1];
      8'h14: rdata_d[7:0] = period_q[1];
      8'h18: rdata_d[7:0] = count_q[1];
      8'h20: rdata_d[6:0] = ctl_q[2];
      8'h24: rdata_d[7:0] = period_q[2];
      8'h28: rdata_d[7:0] = count_q[2];
      ADDR_TIME_BASE_SEL: rdata_d[7:0] = sel_q;
      8'h34: rdata_d[3:0] = mode_q[0];
      8'h38: rdata_d[15:0] = value_q[0];
      8'h3C: rdata_d[3:0] = mode_q[1];
      8'h40: rdata_d[15:0] = value_q[1];
      ADDR_FLAGS: begin
        rdata_d[FLAG_MATCH_LSB +: NUM_TIMERS] = mflag_q;
        rdata_d[FLAG_CAP_LSB +: NUM_CAPTURE] = cflag_q;
      end
      default: hit_d = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registered outputs to partner logic
  // Every partner pulse leaves a flop one cycle after its event.
  // One shared stage keeps their relative timing exact, at the
  // cost of one cycle of latency against the registers.

  // Output stage flops
  logic [NUM_TIMERS-1:0] match_q;
  logic [NUM_PWM_UNITS-1:0] base_q;
  logic shift_q;
  logic [NUM_TIMERS-1:0] post_q;
  logic [NUM_CAPTURE-1:0] cap_q;

  // One-cycle pulses, all delayed by the same flop stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= '0;
      base_q <= '0;
      shift_q <= 1'b0;
      post_q <= '0;
      cap_q <= '0;
    end else if (clk_en) begin
      match_q <= match_d;
      base_q <= base_d;
      shift_q <= match_d[0];
      post_q <= post_d;
      cap_q <= cap_d;
    end
  end

  // Ports straight from the output stage and the flag registers
  assign period_match = match_q;
  assign pwm_time_base = base_q;
  assign serial_shift_tick = shift_q;
  assign postscaled_match = post_q;
  assign period_match_flag = mflag_q;
  assign capture_event_flag = cflag_q;
  assign capture_strobe = cap_q;

endmodule : period_timer_ccp_capture

// file: verification/period_timer_ccp_capture_assertions.sv
// Checker: port-level timing relations of the period timer block
`timescale 1ns/1ps
module period_timer_ccp_capture_checker
  import period_timer_pkg::*;
#(
  parameter int NUM_TIMERS = 3,
  parameter int NUM_CAPTURE = 2,
  parameter int NUM_PWM_UNITS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic sleep,
  input wire logic [NUM_TIMERS-1:0] period_match,
  input wire logic [NUM_PWM_UNITS-1:0] pwm_time_base,
  input wire logic serial_shift_tick,
  input wire logic [NUM_TIMERS-1:0] postscaled_match,
  input wire logic [NUM_TIMERS-1:0] period_match_flag,
  input wire logic [NUM_CAPTURE-1:0] capture_event_flag,
  input wire logic [NUM_CAPTURE-1:0] capture_strobe
);
  ////////////////////////////////////////
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_shift_tick;
    serial_shift_tick == period_match[0];
  endproperty
  a_shift_tick: assert property (p_shift_tick)
    else $error("shift tick differs from timer a match");
  property p_sleep_quiet;
    $past(sleep) && $past(clk_en) |-> period_match == '0;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("match pulse while asleep");
  property p_one_wait;
    psel && penable && !pready && clk_en |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not after one wait state");
  property p_flag_hold;
    capture_event_flag[0] && !(psel && penable && pwrite) |=> capture_event_flag[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("capture flag dropped without a write");
  property p_flag_strobe;
    $rose(capture_event_flag[1]) |-> capture_strobe[1];
  endproperty
  a_flag_strobe: assert property (p_flag_strobe)
    else $error("capture flag rose without strobe");
  property p_pwm_source;
    |pwm_time_base |-> |period_match;
  endproperty
  a_pwm_source: assert property (p_pwm_source)
    else $error("time base pulse without a timer match");
  property p_post_match;
    postscaled_match[0] |-> period_match[0];
  endproperty
  a_post_match: assert property (p_post_match)
    else $error("postscaled pulse off a match");
  property p_post_flag;
    postscaled_match[2] |-> period_match_flag[2];
  endproperty
  a_post_flag: assert property (p_post_flag)
    else $error("match flag not set by postscaler");
endmodule : period_timer_ccp_capture_checker

bind period_timer_ccp_capture period_timer_ccp_capture_checker #(
  .NUM_TIMERS(NUM_TIMERS), .NUM_CAPTURE(NUM_CAPTURE), .NUM_PWM_UNITS(NUM_PWM_UNITS)
) u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .pready, .sleep, .period_match,
  .pwm_time_base, .serial_shift_tick, .postscaled_match, .period_match_flag,
  .capture_event_flag, .capture_strobe);

// file: verification/ccp_far_side.sv
// Far-side model: capture pin source and counter of shift ticks and capture strobes
`timescale 1ns/1ps
module ccp_far_side
  import period_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic serial_shift_tick,
  input wire logic [1:0] capture_strobe,
  output cap_pin_s [1:0] capture_pin
);
  int strobes [2] = '{0, 0};
  int ticks = 0;
  ////////////////////////////////////////
  // Pins start low, as inputs
  initial capture_pin = '0;
  // Running totals; the bench takes differences instead of clearing
  always @(posedge pclk) begin
    ticks <= ticks + int'(serial_shift_tick);
    strobes[0] <= strobes[0] + int'(capture_strobe[0]);
    strobes[1] <= strobes[1] + int'(capture_strobe[1]);
  end
  // Each level held 4 cycles so the two-flop sync sees every edge
  task automatic edges(input int u, input int n, input bit via_port);
    for (int k = 0; k < 2 * n; k++) begin
      @(posedge pclk);
      capture_pin[u].pin_direction_output <= via_port;
      if (via_port)
        capture_pin[u].port_data <= ~capture_pin[u].port_data;
      else
        capture_pin[u].pin_level <= ~capture_pin[u].pin_level;
      repeat (3) @(posedge pclk);
    end
  endtask : edges
endmodule : ccp_far_side

// file: verification/tb_period_timer_ccp_capture.sv
// Testbench: register access, timer spacing, time base pick and capture
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_period_timer_ccp_capture
  import period_timer_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep = 0;
  addr_t paddr = '0;
  logic [31:0] pwdata = '0, prdata, got;
  logic pready, pslverr, last_err, tick;
  logic [15:0] cnt16 = '0;
  cap_pin_s [1:0] pins;
  logic [2:0] pm, post, mflag;
  logic [3:0] ptb, e4;
  logic [1:0] cflag, cstb, cd;
  logic [7:0] sel_tab [2] = '{8'hE4, 8'h1B};
  int exp_cnt [4] = '{16, 16, 4, 1};
  int mismatches = 0, num_checks = 0, cyc = 0, s0, n;

  period_timer_ccp_capture dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep(sleep), .base16_count(cnt16), .capture_pin(pins),
    .period_match(pm), .pwm_time_base(ptb), .serial_shift_tick(tick),
    .postscaled_match(post), .period_match_flag(mflag), .capture_event_flag(cflag),
    .capture_strobe(cstb));
  ccp_far_side far (.pclk(pclk), .serial_shift_tick(tick), .capture_strobe(cstb),
    .capture_pin(pins));

  ////////////////////////////////////////
  // 40 MHz clock and a cycle ceiling against hangs
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 40000) begin
      mismatches++;
      results();
    end
  end
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input addr_t a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    got = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input addr_t a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  task automatic rd(input addr_t a); apb(1'b0, a, 32'h0); endtask : rd
  function automatic addr_t ta(input int t, input addr_t off);
    return TMR_BASE + addr_t'(TMR_STRIDE * t) + off;
  endfunction : ta
  // Spacing of steady pulses; the first interval after a write is partial
  task automatic gap(input bit use_post, output int n);
    for (int j = 0; j < 3; j++) begin
      n = 0;
      do begin @(posedge pclk); n++; end while ((use_post ? post[0] : pm[0]) !== 1'b1 && n < 9000);
    end
  endtask : gap
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      rd(ta(t, OFF_CONTROL));
      `CHK("control reset", 32'h0, got)
      rd(ta(t, OFF_PERIOD));
      `CHK("period reset", 32'hFF, got)
    end
    rd(ADDR_TIME_BASE_SEL);
    `CHK("select reset", 32'h0, got)
    rd(8'h48);
    `CHK("unmapped error", 1'b1, last_err)
    wr(ta(0, OFF_CONTROL), 32'hFF);
    rd(ta(0, OFF_CONTROL));
    `CHK("control bit 7", 32'h7F, got)
    // Period 3 gives a match every 4 prescaled ticks
    wr(ta(0, OFF_PERIOD), 32'h3);
    for (int p = 0; p < 4; p++) begin
      wr(ta(0, OFF_CONTROL), 32'h4 + p);
      gap(1'b0, n);
      `CHK("match spacing", 4 << (2 * p), n)
    end
    for (int q = 1; q < 17; q += 14) begin
      wr(ta(0, OFF_CONTROL), 32'h4 + (q << 3));
      gap(1'b1, n);
      `CHK("postscaled spacing", 4 * (q + 1), n)
    end
    // Stopped timer holds count; control write leaves it alone
    wr(ta(0, OFF_CONTROL), 32'h0);
    wr(ta(0, OFF_COUNT), 32'h5);
    repeat (10) @(posedge pclk);
    rd(ta(0, OFF_COUNT));
    `CHK("count when off", 32'h5, got)
    wr(ta(0, OFF_CONTROL), 32'h8);
    rd(ta(0, OFF_COUNT));
    `CHK("count after control write", 32'h5, got)
    wr(ta(0, OFF_CONTROL), 32'h4);
    sleep <= 1'b1;
    rd(ta(0, OFF_COUNT));
    `CHK("count entering sleep", 32'h5, got)
    repeat (20) @(posedge pclk);
    rd(ta(0, OFF_COUNT));
    `CHK("count in sleep", 32'h5, got)
    rd(ta(0, OFF_PERIOD));
    `CHK("period in sleep", 32'h3, got)
    sleep <= 1'b0;
    // Three timers with distinct periods, then two unit-to-timer maps
    wr(ta(1, OFF_PERIOD), 32'h2);
    wr(ta(2, OFF_PERIOD), 32'h4);
    wr(ta(1, OFF_CONTROL), 32'h4);
    wr(ta(2, OFF_CONTROL), 32'h4);
    // Timer a restarts below its period, so all three pulse in the windows
    wr(ta(0, OFF_COUNT), 32'h0);
    repeat (8) @(posedge pclk);
    s0 = far.ticks;
    repeat (40) @(posedge pclk);
    `CHK("shift ticks", 10, far.ticks - s0)
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_TIME_BASE_SEL, {24'h0, sel_tab[i]});
      rd(ADDR_TIME_BASE_SEL);
      `CHK("select readback", {24'h0, sel_tab[i]}, got)
      repeat (2) @(posedge pclk);
      for (int c = 0; c < 30; c++) begin
        @(posedge pclk);
        for (int u = 0; u < 4; u++) begin
          cd = sel_tab[i][2*u+:2];
          e4[u] = (cd == PICK_RESERVED) ? 1'b0 : pm[cd];
        end
        `CHK("time base", e4, ptb)
      end
    end
    rd(ADDR_FLAGS);
    `CHK("match flags", 3'h7, got[2:0])
    `CHK("match flag pins", 3'h7, mflag)
    // Every capture mode, 16 pulses each; later captures overwrite
    for (int m = 0; m < 4; m++) begin
      wr(CAP_BASE + OFF_CAP_MODE, 32'h0);
      wr(CAP_BASE + OFF_CAP_MODE, 32'(MODE_CAP_FALL) + m);
      wr(ADDR_FLAGS, 32'h30);
      cnt16 <= 16'hA000 + 16'(m);
      s0 = far.strobes[0];
      far.edges(0, 16, 1'b0);
      repeat (4) @(posedge pclk);
      `CHK("capture count", exp_cnt[m], far.strobes[0] - s0)
      rd(CAP_BASE + OFF_CAP_VALUE);
      `CHK("capture value", 32'hA000 + m, got)
      rd(ADDR_FLAGS);
      `CHK("capture flag", 1'b1, got[FLAG_CAP_LSB])
      `CHK("capture flag pin", 1'b1, cflag[0])
    end
    // Second unit as output: port data writes act as edges
    wr(CAP_BASE + CAP_STRIDE + OFF_CAP_MODE, 32'(MODE_CAP_RISE));
    cnt16 <= 16'h1234;
    s0 = far.strobes[1];
    far.edges(1, 4, 1'b1);
    repeat (4) @(posedge pclk);
    `CHK("port edge captures", 4, far.strobes[1] - s0)
    rd(CAP_BASE + CAP_STRIDE + OFF_CAP_VALUE);
    `CHK("second unit value", 32'h1234, got)
    wr(ADDR_FLAGS, 32'h30);
    rd(ADDR_FLAGS);
    `CHK("flags cleared", 2'h0, got[5:4])
    `CHK("flag pins cleared", 2'h0, cflag)
    results();
  end
endmodule : tb_period_timer_ccp_capture
